// ### logic/gpt_pkg.sv
// Contract
// - Toggle strobe write inverts output bits written one
// - Toggle strobe reads return output level register
// - Input value bit shows sampled pin level
// - Input value write toggles output bits written one
// - Disabled input buffer holds previous input bit
// - Flag sets when pin matches sense condition
// - Writing one clears event flag, zero ignored
// - Slew bit zero limits off, one on
// - Invert bit inverts input and output values
// - Pull-up active only while pin input-only
// - Sense zero: buffer on, no events
// - Sense one both, two rising, three falling
// - Sense four disables events and input buffer
// - Sense five low level; six, seven reserved
// - Alias map offsets zero-three act identically
// - Direction zero input-only, one drives output
// - Direction sets driver and masks pull-up, sense gates buffer
// - Output level drives pin when driver enabled
package gpt_pkg;
    localparam logic [5:0] GPT_ADDR_ALIAS_DIR = 6'h00;
    localparam logic [5:0] GPT_ADDR_ALIAS_OUT = 6'h01;
    localparam logic [5:0] GPT_ADDR_ALIAS_IN = 6'h02;
    localparam logic [5:0] GPT_ADDR_ALIAS_FLAGS = 6'h03;
    localparam logic [5:0] GPT_ADDR_OUT_TOGGLE = 6'h07;
    localparam logic [5:0] GPT_ADDR_IN = 6'h08;
    localparam logic [5:0] GPT_ADDR_FLAGS = 6'h09;
    localparam logic [5:0] GPT_ADDR_SLEW = 6'h0a;
    localparam logic [5:0] GPT_ADDR_PINCFG0 = 6'h10;
    localparam logic [5:0] GPT_ADDR_PINCFG7 = 6'h17;
    localparam int GPT_CFG_INVERT_BIT = 7;
    localparam int GPT_CFG_PULLUP_BIT = 3;
    localparam int GPT_CFG_SENSE_LSB = 0;
    localparam int GPT_SLEW_BIT = 0;
    localparam logic [7:0] GPT_CFG_MASK = 8'h8f;
    localparam logic [7:0] GPT_RESET_BYTE = 8'h00;
    localparam logic [2:0] GPT_SENSE_NO_IRQ = 3'h0;
    localparam logic [2:0] GPT_SENSE_ANY_EDGE = 3'h1;
    localparam logic [2:0] GPT_SENSE_RISE = 3'h2;
    localparam logic [2:0] GPT_SENSE_FALL = 3'h3;
    localparam logic [2:0] GPT_SENSE_BUF_OFF = 3'h4;
    localparam logic [2:0] GPT_SENSE_LOW = 3'h5;
endpackage

// ### logic/gpt_cfg_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// Pin config store, eight bytes, registered read
// ********************
module gpt_cfg_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data_q,
    output logic [63:0] all_q
);
    import gpt_pkg::*;

    logic [7:0] mem_q [8];

    // Writes mask the reserved bits so they read back as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                mem_q[i] <= GPT_RESET_BYTE;
            end
        end else if (wr_en) begin
            mem_q[wr_idx] <= wr_data & GPT_CFG_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= GPT_RESET_BYTE;
        end else begin
            rd_data_q <= mem_q[rd_idx];
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            all_q[i*8 +: 8] = mem_q[i];
        end
    end
endmodule
`default_nettype wire

// ### logic/gpt_port.sv
`timescale 1ns/10ps
`default_nettype none
module gpt_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out_q,
    output logic [7:0] pin_oe_q,
    output logic [7:0] pullup_en_q,
    output logic slew_limit_q,
    output logic port_irq_q
);
    import gpt_pkg::*;

    // ********************
    // Registers
    // ********************
    logic [7:0] dir_q;
    logic [7:0] out_q;
    logic [7:0] in_q;
    logic [7:0] flags_q;
    logic slew_en_q;
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] sync3_q;
    logic [7:0] stable_q;
    logic [7:0] prev_q;
    logic [7:0] pin_lvl_d;
    logic [7:0] evt_d;
    logic [7:0] buf_on;
    logic [7:0] inv;
    logic [63:0] cfg_all;
    logic [7:0] cfg_rd;
    logic cfg_sel_q;
    logic [7:0] direct_rd_q;
    logic wr_dir;
    logic wr_out;
    logic wr_tgl;
    logic wr_flags;
    logic wr_cfg;

    function automatic logic [5:0] fold_alias(input logic [5:0] a);
        // Alias offsets map onto their regular counterpart
        case (a)
            GPT_ADDR_ALIAS_OUT: fold_alias = 6'h04;
            GPT_ADDR_ALIAS_IN: fold_alias = GPT_ADDR_IN;
            GPT_ADDR_ALIAS_FLAGS: fold_alias = GPT_ADDR_FLAGS;
            default: fold_alias = a;
        endcase
    endfunction

    function automatic logic [2:0] sense_of(input logic [63:0] c, input int n);
        sense_of = c[n*8 + GPT_CFG_SENSE_LSB +: 3];
    endfunction

    logic [5:0] addr_f;
    assign addr_f = fold_alias(reg_addr);
    assign wr_dir = reg_wr && addr_f == GPT_ADDR_ALIAS_DIR;
    assign wr_out = reg_wr && addr_f == 6'h04;
    assign wr_tgl = reg_wr && (addr_f == GPT_ADDR_OUT_TOGGLE || addr_f == GPT_ADDR_IN);
    assign wr_flags = reg_wr && addr_f == GPT_ADDR_FLAGS;
    assign wr_cfg = reg_wr && addr_f >= GPT_ADDR_PINCFG0 && addr_f <= GPT_ADDR_PINCFG7;

    gpt_cfg_mem u_cfg (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(wr_cfg),
        .wr_idx(addr_f[2:0]),
        .wr_data(reg_wdata),
        .rd_idx(addr_f[2:0]),
        .rd_data_q(cfg_rd),
        .all_q(cfg_all)
    );

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            inv[i] = cfg_all[i*8 + GPT_CFG_INVERT_BIT];
            buf_on[i] = sense_of(cfg_all, i) != GPT_SENSE_BUF_OFF;
        end
    end

    // ********************
    // Direction and output level
    // ********************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= GPT_RESET_BYTE;
        end else if (wr_dir) begin
            dir_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= GPT_RESET_BYTE;
        end else if (wr_out) begin
            out_q <= reg_wdata;
        end else if (wr_tgl) begin
            out_q <= out_q ^ reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slew_en_q <= 1'b0;
        end else if (reg_wr && addr_f == GPT_ADDR_SLEW) begin
            slew_en_q <= reg_wdata[GPT_SLEW_BIT];
        end
    end

    // ********************
    // Pad drive
    // ********************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_q <= GPT_RESET_BYTE;
            pin_oe_q <= GPT_RESET_BYTE;
            pullup_en_q <= GPT_RESET_BYTE;
            slew_limit_q <= 1'b0;
        end else begin
            pin_out_q <= out_q ^ inv;
            pin_oe_q <= dir_q;
            slew_limit_q <= slew_en_q;
            for (int i = 0; i < 8; i++) begin
                pullup_en_q[i] <= cfg_all[i*8 + GPT_CFG_PULLUP_BIT] & ~dir_q[i];
            end
        end
    end

    // ********************
    // Input sampling, three stages, change taken when 2 and 3 agree
    // ********************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= GPT_RESET_BYTE;
            sync2_q <= GPT_RESET_BYTE;
            sync3_q <= GPT_RESET_BYTE;
            stable_q <= GPT_RESET_BYTE;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < 8; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    stable_q[i] <= sync3_q[i];
                end
            end
        end
    end

    assign pin_lvl_d = stable_q ^ inv;

    // Disabled buffers freeze both the input bit and the edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_q <= GPT_RESET_BYTE;
            prev_q <= GPT_RESET_BYTE;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (buf_on[i]) begin
                    in_q[i] <= pin_lvl_d[i];
                    prev_q[i] <= pin_lvl_d[i];
                end
            end
        end
    end

    // ********************
    // Event detection and flags
    // ********************
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            case (sense_of(cfg_all, i))
                GPT_SENSE_ANY_EDGE: evt_d[i] = pin_lvl_d[i] ^ prev_q[i];
                GPT_SENSE_RISE: evt_d[i] = pin_lvl_d[i] & ~prev_q[i];
                GPT_SENSE_FALL: evt_d[i] = ~pin_lvl_d[i] & prev_q[i];
                GPT_SENSE_LOW: evt_d[i] = ~pin_lvl_d[i];
                GPT_SENSE_NO_IRQ: evt_d[i] = 1'b0;
                default: evt_d[i] = 1'b0;
            endcase
        end
    end

    // A new event in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= GPT_RESET_BYTE;
        end else begin
            flags_q <= (flags_q & ~(wr_flags ? reg_wdata : 8'h00)) | evt_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_irq_q <= 1'b0;
        end else begin
            port_irq_q <= |flags_q;
        end
    end

    // ********************
    // Read path, one cycle latency
    // ********************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            direct_rd_q <= GPT_RESET_BYTE;
            cfg_sel_q <= 1'b0;
        end else if (reg_rd) begin
            cfg_sel_q <= addr_f >= GPT_ADDR_PINCFG0 && addr_f <= GPT_ADDR_PINCFG7;
            case (addr_f)
                GPT_ADDR_ALIAS_DIR: direct_rd_q <= dir_q;
                6'h04: direct_rd_q <= out_q;
                GPT_ADDR_OUT_TOGGLE: direct_rd_q <= out_q;
                GPT_ADDR_IN: direct_rd_q <= in_q;
                GPT_ADDR_FLAGS: direct_rd_q <= flags_q;
                GPT_ADDR_SLEW: direct_rd_q <= {7'h00, slew_en_q};
                default: direct_rd_q <= GPT_RESET_BYTE;
            endcase
        end
    end

    assign reg_rdata_q = cfg_sel_q ? cfg_rd : direct_rd_q;
endmodule
`default_nettype wire

// ### tb/gpt_port_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// Port checker
// ***
module gpt_port_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic [7:0] pin_out_q,
    input wire logic [7:0] pin_oe_q,
    input wire logic [7:0] pullup_en_q,
    input wire logic slew_limit_q,
    input wire logic port_irq_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Two edges: register, then pin; writes are never closer than two cycles
    AST_TGL: assert property (reg_wr && reg_addr == 6'h07 |=> ##1
        (pin_out_q ^ $past(pin_out_q)) == $past(reg_wdata, 2)) else $error("tgl");
    AST_IN_WR: assert property (reg_wr && reg_addr == 6'h08 |=> ##1
        (pin_out_q ^ $past(pin_out_q)) == $past(reg_wdata, 2)) else $error("in wr");
    AST_ALIAS_IN: assert property (reg_wr && reg_addr == 6'h02 |=> ##1
        (pin_out_q ^ $past(pin_out_q)) == $past(reg_wdata, 2)) else $error("alias");
    AST_OE: assert property (reg_wr && reg_addr == 6'h00 |=> ##1
        pin_oe_q == $past(reg_wdata, 2)) else $error("oe");
    AST_SLEW: assert property (reg_wr && reg_addr == 6'h0a |=> ##1
        slew_limit_q == $past(reg_wdata[0], 2)) else $error("slew");
    AST_PU: assert property ((pullup_en_q & pin_oe_q) == 8'h00) else $error("pu");
    AST_IRQ: assert property (reg_rd && reg_addr == 6'h09 |=>
        port_irq_q == (reg_rdata_q != 8'h00)) else $error("irq");
    AST_CFG_OE: assert property (reg_wr && reg_addr[5:3] == 3'b010 |=>
        ##1 $stable(pin_oe_q)) else $error("cfg oe");
endmodule
bind gpt_port gpt_port_checker chk_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .pullup_en_q(pullup_en_q),
    .slew_limit_q(slew_limit_q), .port_irq_q(port_irq_q));
`default_nettype wire

// ### tb/gpt_pins.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// Pads and outside sources
// ***
module gpt_pins (
    input wire logic clk,
    input wire logic [7:0] pin_out_q,
    input wire logic [7:0] pin_oe_q,
    input wire logic [7:0] pullup_en_q,
    input wire logic [7:0] ext_lvl,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_lvl
);
    logic [7:0] held_q = 8'h00;
    logic [7:0] drv;
    assign drv = pin_oe_q | ext_en;
    // A bare pin without pull-up flips from its last driven level; with pull-up it reads one
    assign pin_lvl = (pin_oe_q & pin_out_q) | (~pin_oe_q & ext_en & ext_lvl)
        | (~drv & (pullup_en_q | ~held_q));
    always_ff @(posedge clk) begin
        held_q <= (drv & pin_lvl) | (~drv & held_q);
    end
endmodule
`default_nettype wire

// ### tb/gpt_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
module gpt_port_bench;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sl, irq;
    logic [5:0] ad = 6'h00;
    logic [7:0] wd = 8'h00, ext = 8'h00, een = 8'hff, rq, po, oe, pu, pl, d;
    logic [7:0] m_dir = 8'h00, m_out = 8'h00, m_in = 8'h00, m_flg = 8'h00, m_s = 8'h00;
    logic [7:0] cfg [8] = '{default: 8'h00};
    logic [5:0] ra [11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h10,
        6'h17, 6'h0b};
    logic [5:0] ta [3] = '{6'h07, 6'h08, 6'h02};
    int bad_count = 0, num_checks = 0;
    gpt_port dut (.clk(clk), .rst_n(rst_n), .reg_addr(ad), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wd), .reg_rdata_q(rq), .pin_in(pl), .pin_out_q(po), .pin_oe_q(oe),
        .pullup_en_q(pu), .slew_limit_q(sl), .port_irq_q(irq));
    gpt_pins pins (.clk(clk), .pin_out_q(po), .pin_oe_q(oe), .pullup_en_q(pu),
        .ext_lvl(ext), .ext_en(een), .pin_lvl(pl));
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [7:0] col(int b);
        for (int n = 0; n < 8; n++) col[n] = cfg[n][b];
    endfunction
    // Pin level after inversion, valid while every port driver is off and each pin without pull-up is driven from outside
    function automatic logic [7:0] pv();
        pv = ((een & ext) | (~een & col(3))) ^ col(7);
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [5:0] a, input logic [7:0] v);
        ad = a;
        wd = v;
        wr = 1'b1;
        @(posedge clk) #1 wr = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rreg(input logic [5:0] a, input logic [7:0] e);
        ad = a;
        rd = 1'b1;
        @(posedge clk) #1 rd = 1'b0;
        chk(rq, e);
        @(posedge clk) #1;
    endtask
    task automatic settle();
        logic [7:0] p;
        logic [2:0] s;
        repeat (10) @(posedge clk);
        #1 p = pv();
        for (int n = 0; n < 8; n++) begin
            s = cfg[n][2:0];
            if (s == 3'h1 && p[n] != m_s[n] || s == 3'h2 && p[n] && !m_s[n]
                || s == 3'h3 && !p[n] && m_s[n] || s == 3'h5 && !p[n]) m_flg[n] = 1'b1;
            if (s != 3'h4) begin
                m_in[n] = p[n];
                m_s[n] = p[n];
            end
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #500000;
        bad_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(17410));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        wreg(6'h0b, 8'hff);
        foreach (ra[i]) rreg(ra[i], 8'h00);
        chk(po | oe | pu, 8'h00);
        $display("reset done");
        for (int k = 0; k < 9; k++) begin
            m_dir = 8'($urandom);
            wreg(6'h00, m_dir);
            m_out = 8'($urandom);
            wreg(6'h01, m_out);
            d = 8'($urandom);
            wreg(ta[k % 3], d);
            m_out ^= d;
            rreg(6'h07, m_out);
            rreg(6'h04, m_out);
            chk(po, m_out);
            chk(oe, m_dir);
        end
        $display("output done");
        wreg(6'h0a, 8'hff);
        rreg(6'h0a, 8'h01);
        chk(8'(sl), 8'h01);
        wreg(6'h0a, 8'h00);
        // The pad copy of the slew bit lags the register by one more edge
        @(posedge clk) #1;
        chk(8'(sl), 8'h00);
        $display("slew done");
        repeat (3) begin
            een = 8'hff;
            for (int n = 0; n < 8; n++) begin
                d = 8'($urandom);
                cfg[n] = d & 8'h8f;
                wreg(6'h10 + 6'(n), d);
                rreg(6'h10 + 6'(n), cfg[n]);
            end
            chk(pu, col(3) & ~m_dir);
            chk(po, m_out ^ col(7));
            m_dir = 8'h00;
            wreg(6'h00, m_dir);
            m_s = pv();
            settle();
            wreg(6'h09, 8'hff);
            m_flg = 8'h00;
            settle();
            repeat (8) begin
                ext = 8'($urandom);
                een = 8'($urandom) | ~col(3);
                settle();
                rreg(6'h08, m_in);
                rreg(6'h02, m_in);
                rreg(6'h09, m_flg);
                chk(8'(irq), 8'(m_flg != 8'h00));
                d = 8'($urandom);
                wreg(6'h03, d);
                m_flg &= ~d;
                settle();
                rreg(6'h09, m_flg);
            end
        end
        $display("sense done");
        end_of_test();
    end
endmodule
`default_nettype wire
